// file: logic/pidr_pkg.sv
// Purpose: Constants and types for the process PID regulator.
// Assumes: 125 MHz clock, 10 ms control tick, 0.01 % fixed-point units.
// Notes: Register index = byte address / 4.
package pidr_pkg;
    // Clock and tick timing
    localparam int CLK_FREQ_MHZ = 125;
    localparam int TICK_TIME_US = 10000;
    localparam int TICK_CYC = TICK_TIME_US * CLK_FREQ_MHZ;
    // Derivative time is set in ms, loss time in 0.1 s
    localparam int TD_MS_PER_TICK = TICK_TIME_US / 1000;
    localparam int LOSS_UNIT_US = 100000;
    localparam int LOSS_UNIT_TICKS = LOSS_UNIT_US / TICK_TIME_US;
    // Fixed point: 10000 = 100.00 %, gain 1000 = 100.0
    localparam int FULL = 10000;
    localparam int KP_FULL = 1000;
    localparam int IFRAC = 16;
    // Register indices
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_KP1 = 5'h01;
    localparam logic [4:0] A_TI1 = 5'h02;
    localparam logic [4:0] A_KP2 = 5'h04;
    localparam logic [4:0] A_TI2 = 5'h05;
    localparam logic [4:0] A_THR1 = 5'h07;
    localparam logic [4:0] A_THR2 = 5'h08;
    localparam logic [4:0] A_DBAND = 5'h09;
    localparam logic [4:0] A_DLIM = 5'h0A;
    localparam logic [4:0] A_RAMP_T = 5'h0B;
    localparam logic [4:0] A_FBF_T = 5'h0C;
    localparam logic [4:0] A_OUTF_T = 5'h0D;
    localparam logic [4:0] A_INIT = 5'h0E;
    localparam logic [4:0] A_HOLD_T = 5'h0F;
    localparam logic [4:0] A_SLEW_F = 5'h10;
    localparam logic [4:0] A_SLEW_R = 5'h11;
    localparam logic [4:0] A_LOSS_THR = 5'h12;
    localparam logic [4:0] A_LOSS_T = 5'h13;
    localparam logic [4:0] A_REVCUT = 5'h14;
    localparam logic [4:0] A_MAXF = 5'h15;
    localparam logic [4:0] A_IPROP = 5'h16;
    localparam logic [4:0] A_OUT = 5'h17;
    localparam logic [4:0] A_STAT = 5'h18;
    localparam int NCFG = 23;
    // CTRL bits
    localparam int C_NEG = 0;
    localparam int C_MODE = 1;
    localparam int C_STOPOP = 3;
    localparam int C_FCLR = 4;
    // Reset values, in index order
    localparam logic [15:0] CFG_RST [0:NCFG-1] = '{
        16'h0000, 16'h00C8, 16'h00C8, 16'h0000, 16'h00C8, 16'h00C8,
        16'h0000, 16'h07D0, 16'h1F40, 16'h0000, 16'h000A, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064,
        16'h0000, 16'h0000, 16'h00C8, 16'h1388, 16'h0000};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [15:0] kp;
        logic [15:0] ti;
        logic [15:0] td;
    } pidr_gain_t;
    typedef enum {ST_IDLE, ST_HOLD, ST_RUN} pidr_state_t;
endpackage

// file: logic/pidr_top.sv
// Purpose: Process PID regulator producing a signed frequency reference.
// Assumes: Setpoint, feedback and run come from logic on I_CLOCK.
// Notes: Output unit 0.01 % of maximum frequency, sign = direction.
`timescale 1ns/1ps
// How it works
// - Derivative: full-range change within derivative time gives max frequency.
// - Reverse output magnitude capped at reverse cut-off frequency.
// - Error below dead band holds the output and integrator.
// - Derivative term clamped to the derivative limit.
// - Setpoint ramps linearly; full range takes the change time.
// - Feedback low-pass filtered; zero time bypasses it.
// - Output low-pass filtered; zero time bypasses it.
// - Two gain sets with identical ranges.
// - Gain mode: 0 set one, 1 terminal, 2 by error.
// - Terminal mode: pin off selects set one, on set two.
// - Auto mode interpolates gains between two error thresholds.
// - At start output held at initial value for holding time.
// - Step between outputs limited separately upward and downward.
// - Integral separation freezes integrator while pause pin on.
// - Anti-windup stops integrating while output saturated.
// - Feedback below loss threshold too long raises loss fault.
// - Stop-operation setting keeps regulator running while stopped.
// - Gain 100.0 with full error gives maximum frequency.
// - Full error over integral time integrates to maximum frequency.
// - Negative characteristic inverts the error sign.
module pidr_top import pidr_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire logic I_CLK_EN,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [7:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    input wire logic I_RUN,
    input wire logic [15:0] I_SETPOINT,
    input wire logic [15:0] I_FEEDBACK,
    input wire logic I_GAIN_SEL_PIN,
    input wire logic I_INTEG_PAUSE_PIN,
    output logic signed [15:0] O_FREQ_REF,
    output logic O_LOSS_FAULT
);
    logic [15:0] cfg_q [0:NCFG-1];
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [1:0] sel_sync_q, pause_sync_q;
    logic [31:0] tick_cnt_q;
    logic run_q;
    pidr_state_t state_q;
    logic [15:0] hold_cnt_q, loss_cnt_q;
    logic signed [31:0] sp_q, fbf_q, fbp_q, out_q;
    logic signed [15:0] of_q;
    logic signed [47:0] acc_q;
    logic sat_q, fault_q;

    // Bus decode
    wire [4:0] widx = awaddr_q[6:2];
    wire [4:0] ridx = I_ARADDR[6:2];
    wire wr_go = aw_full_q && w_full_q && !bvalid_q;
    wire wr_hit = !awaddr_q[7] && widx < 5'(NCFG);
    wire rd_go = I_ARVALID && !rvalid_q;
    wire rd_cfg = !I_ARADDR[7] && ridx < 5'(NCFG);
    wire rd_hit = rd_cfg || (!I_ARADDR[7] && (ridx == A_OUT || ridx == A_STAT));
    wire fault_clr = wr_go && widx == A_CTRL && wstrb_q[0] && wdata_q[C_FCLR];
    wire [31:0] status = {27'h0, sel_sync_q[1], fault_q, sat_q, state_q == ST_RUN,
        state_q == ST_HOLD};
    // Refused reads return zero, upper half of the map included
    wire [31:0] rd_val = !rd_hit ? 32'h0 : rd_cfg ? {16'h0, cfg_q[ridx]} :
        ridx == A_OUT ? {{16{of_q[15]}}, of_q} :
        ridx == A_STAT ? status : 32'h0;
    assign O_AWREADY = !aw_full_q;
    assign O_WREADY = !w_full_q;
    assign O_BVALID = bvalid_q;
    assign O_BRESP = bresp_q;
    assign O_ARREADY = !rvalid_q;
    assign O_RVALID = rvalid_q;
    assign O_RDATA = rdata_q;
    assign O_RRESP = rresp_q;

    // Write channel: address and data held until both present
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
        end else if (I_CLK_EN) begin
            if (I_AWVALID && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q <= I_AWADDR;
            end
            if (I_WVALID && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q <= I_WDATA;
                wstrb_q <= I_WSTRB;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && I_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel: one cycle to data
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (I_CLK_EN) begin
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_val;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (I_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Configuration words, low two byte lanes only
    for (genvar g = 0; g < NCFG; g++) begin : g_cfg
        always_ff @(posedge I_CLOCK) begin
            if (!I_RESET_N) begin
                cfg_q[g] <= CFG_RST[g];
            end else if (I_CLK_EN && wr_go && widx == 5'(g)) begin
                if (wstrb_q[0]) cfg_q[g][7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) cfg_q[g][15:8] <= wdata_q[15:8];
            end
        end
    end

    // Control fields
    wire neg_char = cfg_q[A_CTRL][C_NEG];
    wire [1:0] gmode = cfg_q[A_CTRL][C_MODE +: 2];
    wire stop_op = cfg_q[A_CTRL][C_STOPOP];
    wire integ_sep = cfg_q[A_IPROP] % 16'd10 == 16'd1;
    wire anti_wind = cfg_q[A_IPROP] / 16'd10 == 16'd1;
    wire active = run_q || stop_op;
    wire tick = I_CLK_EN && tick_cnt_q == 32'(TICK_CYCLES - 1);

    // Setpoint ramp and feedback filter
    wire signed [31:0] sp_in = {16'h0, I_SETPOINT};
    wire signed [31:0] fb_in = {16'h0, I_FEEDBACK};
    wire signed [31:0] ramp_t = {16'h0, cfg_q[A_RAMP_T]};
    wire signed [31:0] ramp_step = ramp_t == 0 ? FULL : (FULL / ramp_t > 0 ? FULL / ramp_t : 1);
    wire signed [31:0] sp_dif = sp_in - sp_q;
    wire signed [31:0] sp_d = sp_dif > ramp_step ? sp_q + ramp_step :
        sp_dif < -ramp_step ? sp_q - ramp_step : sp_in;
    wire signed [31:0] fbf_d = fbf_q + (fb_in - fbf_q) / ($signed({16'h0, cfg_q[A_FBF_T]}) + 1);

    // Error with characteristic, and its magnitude
    wire signed [31:0] err_raw = sp_q - fbf_q;
    wire signed [31:0] err = neg_char ? -err_raw : err_raw;
    wire signed [31:0] aerr = err < 0 ? -err : err;
    wire in_band = aerr < $signed({16'h0, cfg_q[A_DBAND]});

    // Gain blend between the two sets
    function automatic logic [15:0] blend(input logic [15:0] a, input logic [15:0] b,
        input logic signed [31:0] e, input logic [15:0] t1, input logic [15:0] t2);
        logic signed [31:0] lo, hi, v;
        lo = {16'h0, t1};
        hi = {16'h0, t2};
        v = $signed({16'h0, a});
        if (e >= hi) v = {16'h0, b};
        else if (e > lo) v = v + ($signed({16'h0, b}) - v) * (e - lo) / (hi - lo);
        return v[15:0];
    endfunction
    pidr_gain_t g1, g2, gs;
    assign g1 = {cfg_q[A_KP1], cfg_q[A_KP1 + 5'd1], cfg_q[A_KP1 + 5'd2]};
    assign g2 = {cfg_q[A_KP2], cfg_q[A_KP2 + 5'd1], cfg_q[A_KP2 + 5'd2]};
    // Terminal or error-driven selection; mode 3 behaves as 0
    always_comb begin
        gs = g1;
        if (gmode == 2'd1 && sel_sync_q[1]) begin
            gs = g2;
        end else if (gmode == 2'd2) begin
            gs.kp = blend(g1.kp, g2.kp, aerr, cfg_q[A_THR1], cfg_q[A_THR2]);
            gs.ti = blend(g1.ti, g2.ti, aerr, cfg_q[A_THR1], cfg_q[A_THR2]);
            gs.td = blend(g1.td, g2.td, aerr, cfg_q[A_THR1], cfg_q[A_THR2]);
        end
    end

    // Terms
    wire signed [31:0] p_term = err * $signed({16'h0, gs.kp}) / KP_FULL;
    wire signed [31:0] dfb = neg_char ? fbf_q - fbp_q : fbp_q - fbf_q;
    wire signed [31:0] d_raw = dfb * $signed({16'h0, gs.td}) / TD_MS_PER_TICK;
    wire signed [31:0] dlim = {16'h0, cfg_q[A_DLIM]};
    wire signed [31:0] d_term = d_raw > dlim ? dlim : d_raw < -dlim ? -dlim : d_raw;
    wire signed [31:0] ti_eff = gs.ti == 16'h0 ? 32'sd1 : {16'h0, gs.ti};
    wire signed [47:0] acc_inc = (48'(err) <<< IFRAC) / 48'(ti_eff);
    wire i_freeze = (integ_sep && pause_sync_q[1]) || (anti_wind && sat_q);
    wire signed [47:0] acc_sum = i_freeze ? acc_q : acc_q + acc_inc;
    wire signed [47:0] acc_max = 48'(FULL) <<< IFRAC;
    wire signed [47:0] acc_d = acc_sum > acc_max ? acc_max :
        acc_sum < -acc_max ? -acc_max : acc_sum;
    wire signed [31:0] i_term = 32'(acc_q >>> IFRAC);
    wire signed [31:0] u_sum = p_term + i_term + d_term;
    wire sat_d = u_sum >= FULL || u_sum <= -FULL;
    wire signed [31:0] u_lim = u_sum > FULL ? FULL : u_sum < -FULL ? -FULL : u_sum;

    // Reverse cap in percent of maximum frequency
    wire signed [31:0] maxf = cfg_q[A_MAXF] == 16'h0 ? 32'sd1 : {16'h0, cfg_q[A_MAXF]};
    wire signed [31:0] rev_raw = $signed({16'h0, cfg_q[A_REVCUT]}) * FULL / maxf;
    wire signed [31:0] rev_pct = rev_raw > FULL ? FULL : rev_raw;
    wire signed [31:0] u_rev = u_lim < -rev_pct ? -rev_pct : u_lim;

    // Step limit against the previous output
    wire signed [31:0] slew_f = {16'h0, cfg_q[A_SLEW_F]};
    wire signed [31:0] slew_r = {16'h0, cfg_q[A_SLEW_R]};
    wire signed [31:0] step = u_rev - out_q;
    wire signed [31:0] out_d = step > slew_f ? out_q + slew_f :
        step < -slew_r ? out_q - slew_r : u_rev;
    wire signed [31:0] of_ext = {{16{of_q[15]}}, of_q};
    wire signed [31:0] of_d = of_ext + (out_q - of_ext) / ($signed({16'h0, cfg_q[A_OUTF_T]}) + 1);
    wire signed [31:0] init_v = {16'h0, cfg_q[A_INIT]};

    // Feedback loss
    wire loss_low = cfg_q[A_LOSS_THR] != 16'h0 && I_FEEDBACK < cfg_q[A_LOSS_THR];
    wire loss_hit = 32'(loss_cnt_q) > 32'(cfg_q[A_LOSS_T]) * LOSS_UNIT_TICKS;

    // Terminal synchronisers and tick timer
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            sel_sync_q <= 2'b00;
            pause_sync_q <= 2'b00;
            tick_cnt_q <= 32'h0;
        end else if (I_CLK_EN) begin
            sel_sync_q <= {sel_sync_q[0], I_GAIN_SEL_PIN};
            pause_sync_q <= {pause_sync_q[0], I_INTEG_PAUSE_PIN};
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // Sticky loss fault: a set beats a same-cycle clear
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            fault_q <= 1'b0;
            loss_cnt_q <= 16'h0;
        end else if (I_CLK_EN) begin
            if (tick) begin
                loss_cnt_q <= !loss_low ? 16'h0 :
                    loss_cnt_q == 16'hFFFF ? loss_cnt_q : loss_cnt_q + 16'h1;
            end
            fault_q <= (tick && loss_low && loss_hit) || (fault_q && !fault_clr);
        end
    end

    // Regulator sequence, one step per tick
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            state_q <= ST_IDLE;
            run_q <= 1'b0;
            hold_cnt_q <= 16'h0;
            sp_q <= 32'sh0;
            fbf_q <= 32'sh0;
            fbp_q <= 32'sh0;
            out_q <= 32'sh0;
            of_q <= 16'sh0;
            acc_q <= 48'sh0;
            sat_q <= 1'b0;
        end else if (tick) begin
            run_q <= I_RUN;
            sp_q <= sp_d;
            fbf_q <= fbf_d;
            fbp_q <= fbf_q;
            of_q <= of_d[15:0];
            case (state_q)
                ST_IDLE: begin
                    out_q <= 32'sh0;
                    acc_q <= 48'sh0;
                    if (active) begin
                        state_q <= ST_HOLD;
                        hold_cnt_q <= 16'h0;
                        out_q <= init_v;
                    end
                end
                ST_HOLD: begin
                    out_q <= init_v;
                    acc_q <= 48'(init_v) <<< IFRAC;
                    hold_cnt_q <= hold_cnt_q + 16'h1;
                    if (!active) state_q <= ST_IDLE;
                    else if (hold_cnt_q >= cfg_q[A_HOLD_T]) state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (!active) begin
                        state_q <= ST_IDLE;
                    end else if (I_RUN && !run_q) begin
                        state_q <= ST_HOLD;
                        hold_cnt_q <= 16'h0;
                    end else if (!in_band) begin
                        acc_q <= acc_d;
                        out_q <= out_d;
                        sat_q <= sat_d;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign O_FREQ_REF = of_q;
    assign O_LOSS_FAULT = fault_q;
endmodule

// file: tb/pidr_assertions.sv
// Purpose: Port-level checks on the register bus and output timing.
// Assumes: I_CLK_EN held high by the bench.
// Notes: Output spacing counted in a small helper counter.
`timescale 1ns/1ps
module pidr_assertions import pidr_pkg::*; #(
    parameter int TICK_CYCLES = 20
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0] O_RRESP,
    input wire logic signed [15:0] O_FREQ_REF
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    int since_q;
    // Cycles since the output last moved; saturates to stay cheap
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N || $changed(O_FREQ_REF)) since_q <= 0;
        else if (since_q < TICK_CYCLES) since_q <= since_q + 1;
    end
    chk_out_tick_spaced: assert property ($changed(O_FREQ_REF) |-> since_q >= TICK_CYCLES - 1)
        else $error("output moved between ticks");
    chk_aw_held_refused: assert property (I_AWVALID && O_AWREADY |=> !O_AWREADY)
        else $error("address accepted while one is held");
    chk_w_held_refused: assert property (I_WVALID && O_WREADY |=> !O_WREADY)
        else $error("data accepted while one is held");
    chk_write_answer_time: assert property (
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> ##1 O_BVALID)
        else $error("write response late");
    chk_b_released: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write response not released");
    chk_read_answer_time: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
        else $error("read answer late");
    chk_r_released: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read answer not released");
    chk_ar_busy_refused: assert property (O_RVALID |-> !O_ARREADY)
        else $error("read address accepted while answer pending");
    chk_unmapped_read_err: assert property (I_ARVALID && O_ARREADY && I_ARADDR[7:2] > 6'h18
        |=> O_RRESP == RESP_SLVERR && O_RDATA == 32'h0)
        else $error("unmapped read not refused");
    chk_mapped_read_ok: assert property (I_ARVALID && O_ARREADY && I_ARADDR[7:2] <= 6'h18
        |=> O_RRESP == RESP_OKAY)
        else $error("mapped read refused");
endmodule

// file: tb/pidr_source.sv
// Purpose: Setpoint, feedback and terminal source beside the regulator.
// Assumes: The bench sets wanted values; the model launches them on edges.
// Notes: Terminals change only at edges, so sync latency stays fixed.
`timescale 1ns/1ps
module pidr_source (
    input wire logic i_clk,
    input wire logic [15:0] i_sp_want,
    input wire logic [15:0] i_fb_want,
    input wire logic i_sel_want,
    output logic [15:0] o_sp,
    output logic [15:0] o_fb,
    output logic o_sel
);
    // Launch on the edge so no half-updated value is ever sampled
    always_ff @(posedge i_clk) begin
        o_sp <= i_sp_want;
        o_fb <= i_fb_want;
        o_sel <= i_sel_want;
    end
endmodule

// file: tb/pidr_top_tb.sv
// Purpose: Self-checking bench for the process PID regulator.
// Assumes: Tick shortened to 20 clocks; timed settings count ticks.
// Notes: Each scenario restarts from reset so integrators start clean.
`timescale 1ns/1ps
module pidr_top_tb import pidr_pkg::*;;
    localparam int TC = 20;
    logic clk = 0, rst_n = 0, run = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic awr, wrdy, bv, arr, rv, flt, sel, sel_w = 0, pause = 0;
    logic [1:0] br, rr;
    logic signed [15:0] fref;
    logic [15:0] sp_w = 16'h0, fb_w = 16'h0, sp, fb;
    int fails = 0, checked = 0, cyc = 0;
    always #4 clk = ~clk;
    pidr_source src_u (.i_clk(clk), .i_sp_want(sp_w), .i_fb_want(fb_w), .i_sel_want(sel_w),
        .o_sp(sp), .o_fb(fb), .o_sel(sel));
    pidr_top #(.TICK_CYCLES(TC)) dut_u (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_CLK_EN(1'b1),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy),
        .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bre), .O_BRESP(br),
        .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre),
        .O_RDATA(rdat), .O_RRESP(rr), .I_RUN(run), .I_SETPOINT(sp), .I_FEEDBACK(fb),
        .I_GAIN_SEL_PIN(sel), .I_INTEG_PAUSE_PIN(pause), .O_FREQ_REF(fref),
        .O_LOSS_FAULT(flt));
    task automatic summarize;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            summarize();
        end
    end
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic inr(string nm, int lo, int hi);
        check(nm, 32'(fref >= lo && fref <= hi), 32'h1);
    endtask
    task automatic tk(int n);
        repeat (n * TC) @(posedge clk);
    endtask
    task automatic rst;
        @(posedge clk);
        rst_n <= 1'b0;
        run <= 1'b0;
        sp_w <= 16'h0;
        fb_w <= 16'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Address and data offered together, each released once taken
    task automatic wr(logic [5:0] idx, logic [15:0] d, logic [1:0] e = RESP_OKAY);
        @(posedge clk);
        awa <= {idx, 2'b00};
        wd <= {16'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        check("write response", 32'(br), 32'(e));
        bre <= 1'b0;
    endtask
    // Waits for the answer however long; only the hang guard ends a wait
    task automatic rd(logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        d = rdat;
        r = rr;
        rre <= 1'b0;
    endtask
    // Reset values, unmapped place, write back
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < NCFG; i++) begin
            rd(6'(i), d, r);
            check("reset value", d, {16'h0, CFG_RST[i]});
        end
        rd(6'h19, d, r);
        check("unmapped data", d, 32'h0);
        check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
        wr(6'h19, 16'h1234, RESP_SLVERR);
        wr(A_KP1, 16'h0123);
        rd(A_KP1, d, r);
        check("kp readback", d, 32'h0123);
    endtask
    task automatic t_hold;
        rst();
        wr(A_INIT, 16'h0BB8);
        wr(A_HOLD_T, 16'h0008);
        wr(A_SLEW_F, 16'h2710);
        run <= 1'b1;
        tk(4);
        check("held output", 32'(fref), 32'h0BB8);
    endtask
    task automatic t_prop;
        logic signed [15:0] v;
        rst();
        wr(A_KP1, 16'h03E8);
        wr(A_TI1, 16'h03E8);
        wr(A_SLEW_F, 16'h2710);
        wr(A_SLEW_R, 16'h2710);
        sp_w <= 16'h1388;
        run <= 1'b1;
        tk(6);
        inr("full gain", 5000, 5100);
        wr(A_DBAND, 16'h1770);
        tk(2);
        v = fref;
        tk(5);
        check("dead band", 32'(fref), 32'(v));
        wr(A_DBAND, 16'h0000);
        wr(A_CTRL, 16'h0001);
        tk(6);
        check("reverse cap", 32'(fref), 32'hFFFFFE70);
    endtask
    task automatic t_slew;
        logic signed [15:0] v;
        rst();
        wr(A_KP1, 16'h03E8);
        wr(A_SLEW_R, 16'h00C8);
        sp_w <= 16'h1388;
        run <= 1'b1;
        tk(20);
        v = fref;
        tk(1);
        check("slew up", 32'(fref - v), 32'd100);
        sp_w <= 16'h0000;
        tk(4);
        v = fref;
        tk(1);
        check("slew down", 32'(v - fref), 32'd200);
    endtask
    task automatic t_loss;
        rst();
        wr(A_LOSS_THR, 16'h03E8);
        wr(A_LOSS_T, 16'h0001);
        fb_w <= 16'h01F4;
        tk(7);
        fb_w <= 16'h07D0;
        tk(2);
        fb_w <= 16'h01F4;
        tk(7);
        check("loss restart", 32'(flt), 32'h0);
        tk(7);
        check("loss fault", 32'(flt), 32'h1);
        fb_w <= 16'h07D0;
        tk(3);
        check("fault sticky", 32'(flt), 32'h1);
        wr(A_CTRL, 16'h0010);
        tk(2);
        check("fault cleared", 32'(flt), 32'h0);
    endtask
    // Gain modes 0 to 2 once each; terminal on in modes 0 and 1, off in modes 1 and 2
    task automatic t_gain;
        rst();
        wr(A_KP2, 16'h03E8);
        wr(A_TI1, 16'h03E8);
        wr(A_TI2, 16'h03E8);
        wr(A_SLEW_F, 16'h2710);
        wr(A_SLEW_R, 16'h2710);
        sp_w <= 16'h1388;
        sel_w <= 1'b1;
        run <= 1'b1;
        tk(6);
        inr("mode none", 1000, 1100);
        wr(A_CTRL, 16'h0002);
        tk(4);
        inr("terminal on", 5000, 5150);
        sel_w <= 1'b0;
        tk(4);
        inr("terminal off", 1000, 1200);
        wr(A_CTRL, 16'h0004);
        tk(4);
        inr("auto blend", 3000, 3200);
    endtask
    // Running while stopped, integrator paused by its terminal
    task automatic t_stop;
        rst();
        wr(A_CTRL, 16'h0008);
        wr(A_IPROP, 16'h0001);
        wr(A_SLEW_F, 16'h2710);
        sp_w <= 16'h1388;
        pause <= 1'b1;
        tk(6);
        check("stopped frozen", 32'(fref), 32'd1000);
        pause <= 1'b0;
        tk(4);
        inr("integral resumes", 1001, 1200);
    endtask
    initial begin
        rst();
        t_regs();
        t_hold();
        t_prop();
        t_slew();
        t_loss();
        t_gain();
        t_stop();
        summarize();
    end
endmodule
bind pidr_top pidr_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.I_CLOCK(I_CLOCK),
    .I_RESET_N(I_RESET_N), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
    .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .I_ARADDR(I_ARADDR), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_FREQ_REF(O_FREQ_REF));
